// ==== bench/sensor_feed_model.sv ====
// Raw sample source and buffer sink on the sample side of the block
`timescale 1ns/1ps
`default_nettype none
module sensor_feed_model #(
	parameter logic [15:0] GX = 16'h0A00,
	parameter logic [15:0] GY = 16'h0100,
	parameter logic [15:0] GZ = 16'hFFF0
) (
	input  wire logic               mclk_i,  // Clock
	input  wire logic               rst_i,   // Sync reset
	input  wire logic               stb_i,   // Output updated
	input  wire logic               step_i,  // Jump Y rate by a step
	input  wire logic               drain_i, // Sink willing to take
	input  wire logic               valid_i, // Buffer not empty
	output logic                    ready_o, // Buffer pop
	output motion_cfg_pkg::sample_t raw_o    // Raw words
);
	logic [15:0] cnt_q;
	logic [15:0] y_q;

	// Temperature word counts strobes, so buffer order is visible
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			cnt_q <= 16'h0000;
			y_q   <= GY;
		end
		else
		begin
			if (stb_i)
				cnt_q <= cnt_q + 16'h0001;
			if (step_i)
				y_q <= y_q + 16'h0800;
		end
	end

	assign raw_o   = {16'h6666, 16'h5555, 16'h4444, GZ, y_q, GX, cnt_q};
	assign ready_o = drain_i & valid_i;
endmodule
`default_nettype wire

// ==== bench/test_motion_sample_output_config.sv ====
// Self-checking bench for the motion sample output block
`timescale 1ns/1ps
`default_nettype none
module test_motion_sample_output_config;
	localparam logic [15:0] GY   = 16'h0100;
	localparam logic [15:0] GZ   = 16'hFFF0;
	localparam logic [11:0] A_YH = {motion_cfg_pkg::IDX_Y_BIAS_HIGH, 2'b00};
	localparam logic [11:0] A_YL = {motion_cfg_pkg::IDX_Y_BIAS_LOW, 2'b00};
	localparam logic [11:0] A_ZH = {motion_cfg_pkg::IDX_Z_BIAS_HIGH, 2'b00};
	localparam logic [11:0] A_ZL = {motion_cfg_pkg::IDX_Z_BIAS_LOW, 2'b00};
	localparam logic [11:0] A_DV = {motion_cfg_pkg::IDX_RATE_DIV, 2'b00};
	localparam logic [11:0] A_SU = {motion_cfg_pkg::IDX_SETUP, 2'b00};
	localparam logic [11:0] A_GC = {motion_cfg_pkg::IDX_GYRO_CFG, 2'b00};
	localparam logic [11:0] A_ST = {motion_cfg_pkg::IDX_STATUS, 2'b00};
	typedef struct {
		logic [7:0] gcfg;
		logic [7:0] setup;
		logic [7:0] div;
		int         gap;
	} rate_row_t;

	logic                     mclk_i;
	logic                     rst_i;
	motion_cfg_pkg::apb_req_t apb_q;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	motion_cfg_pkg::sample_t  raw;
	motion_cfg_pkg::sample_t  samp;
	motion_cfg_pkg::sample_t  fdata;
	logic                     frame_sync_input;
	logic                     stb;
	logic                     fvalid;
	logic                     fready;
	logic                     step;
	logic                     drain;
	logic [31:0]              rd;
	logic                     er;
	logic                     lat;
	logic [7:0]               d0;
	logic [15:0]              s [6];
	int                       gap;
	int                       miscompares;
	int                       tests_run;
	logic [11:0]              regs [7] = '{A_YH, A_YL, A_ZH, A_ZL, A_DV, A_SU, A_GC};
	rate_row_t                rows [8] = '{
		'{8'h00, 8'h00, 8'h05, 40},
		'{8'h00, 8'h07, 8'h05, 40},
		'{8'h00, 8'h03, 8'h00, 100},
		'{8'h00, 8'h01, 8'h00, 100},
		'{8'h00, 8'h03, 8'h02, 300},
		'{8'h01, 8'h03, 8'h02, 3125},
		'{8'h02, 8'h06, 8'h00, 3125},
		'{8'h03, 8'h05, 8'h04, 3125}
	};

	motion_sample_output_config #(
		.PER_8K_CYC (40),
		.PER_1K_CYC (100),
		.FIFO_DEPTH (4)
	) i_dut (
		.mclk_i             (mclk_i),
		.rst_i              (rst_i),
		.apb_i              (apb_q),
		.prdata_o           (prdata),
		.pready_o           (pready),
		.pslverr_o          (pslverr),
		.raw_i              (raw),
		.frame_sync_input_i (frame_sync_input),
		.samp_o             (samp),
		.samp_stb_o         (stb),
		.fifo_valid_o       (fvalid),
		.fifo_ready_i       (fready),
		.fifo_data_o        (fdata)
	);

	sensor_feed_model #(
		.GY (GY),
		.GZ (GZ)
	) i_feed (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.stb_i   (stb),
		.step_i  (step),
		.drain_i (drain),
		.valid_i (fvalid),
		.ready_o (fready),
		.raw_o   (raw)
	);

	// ----------------------------------------
	// Check, bus and strobe tasks
	// ----------------------------------------
	task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
		tests_run++;
		if (got !== exp)
		begin
			$display("MISMATCH %0t %s", $time, m);
			miscompares++;
		end
	endtask

	task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk_i);
		apb_q <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge mclk_i);
		apb_q.penable <= 1'b1;
		@(posedge mclk_i);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge mclk_i);
			n++;
		end
		rd = prdata;
		er = pslverr;
		apb_q.psel    <= 1'b0;
		apb_q.penable <= 1'b0;
		if (n >= 50)
			chk(1'b0, 1'b1, "no ready");
	endtask

	// Gap holds cycles since the previous strobe seen
	task automatic wstb();
		int n;
		n = 0;
		@(posedge mclk_i);
		while (stb !== 1'b1 && n < 4000)
		begin
			@(posedge mclk_i);
			n++;
		end
		gap = n + 1;
		if (n >= 4000)
			chk(1'b0, 1'b1, "no strobe");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog and sequence
	// ----------------------------------------
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	// Whole sequence needs about 40000 cycles
	initial
	begin
		repeat (90000) @(posedge mclk_i);
		miscompares++;
		report_and_stop();
	end

	initial
	begin
		rst_i = 1'b1;
		apb_q = '0;
		frame_sync_input = 1'b0;
		step = 1'b0;
		drain = 1'b1;
		lat = 1'b0;
		miscompares = 0;
		tests_run = 0;
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
		// Third strobe after a change gives a full period
		foreach (rows[i])
		begin
			apb(A_GC, 1'b1, {24'h0, rows[i].gcfg});
			apb(A_DV, 1'b1, {24'h0, rows[i].div});
			apb(A_SU, 1'b1, {24'h0, rows[i].setup});
			wstb();
			wstb();
			wstb();
			chk(gap, rows[i].gap, "sample spacing");
		end
		// Reset in mid-run
		rst_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		chk({fvalid, stb, samp.word[2]}, 33'h0, "outputs in reset");
		rst_i <= 1'b0;
		foreach (regs[i])
		begin
			apb(regs[i], 1'b0, 32'h0);
			chk({er, rd}, 33'h0, "reset value");
		end
		apb(A_YH, 1'b1, 32'h0000_0001);
		apb(A_YL, 1'b1, 32'hFFFF_FF10);
		apb(A_ZH, 1'b1, 32'h0000_00FF);
		apb(A_ZL, 1'b1, 32'h0000_0020);
		apb(A_YL, 1'b0, 32'h0);
		chk(rd, 32'h0000_0010, "y low readback");
		apb(A_YH, 1'b0, 32'h0);
		chk(rd, 32'h0000_0001, "y high readback");
		apb(A_ZH, 1'b0, 32'h0);
		chk(rd, 32'h0000_00FF, "z high readback");
		apb(A_ZL, 1'b0, 32'h0);
		chk(rd, 32'h0000_0020, "z low readback");
		apb(12'h100, 1'b0, 32'h0);
		chk({er, rd}, 33'h1_0000_0000, "unmapped read");
		apb(A_YL + 12'h001, 1'b1, 32'h0000_0055);
		chk(er, 1'b1, "misaligned write");
		apb(A_YL, 1'b0, 32'h0);
		chk(rd, 32'h0000_0010, "refused write kept");
		wstb();
		wstb();
		wstb();
		chk(samp.word[2], 16'(GY + 16'h0110), "y output");
		chk(samp.word[3], 16'(GZ + 16'hFF20), "z output");
		chk(samp.word[1], 16'h0A00, "x output");
		// Stalled sink: six samples into four places
		for (int m = 1; m >= 0; m--)
		begin
			apb(A_SU, 1'b1, m ? 32'h40 : 32'h00);
			apb(A_ST, 1'b0, 32'h0);
			d0 = rd[15:8];
			wstb();
			drain <= 1'b0;
			for (int k = 0; k < 6; k++)
			begin
				wstb();
				s[k] = samp.word[0];
			end
			apb(A_ST, 1'b0, 32'h0);
			chk(rd[2:0], 3'd4, "buffer level");
			chk(8'(rd[15:8] - d0), m ? 8'd2 : 8'd0, "drop count");
			drain <= 1'b1;
			for (int k = 0; k < 4; k++)
			begin
				@(posedge mclk_i);
				chk(fdata.word[0], s[k + (m ? 0 : 2)], "buffer order");
			end
			@(posedge mclk_i);
			chk(fvalid, 1'b0, "buffer empty");
		end
		// Short pulse right after a strobe: two edges, one flip
		for (int sel = 1; sel < 8; sel++)
		begin
			apb(A_SU, 1'b1, 32'(sel << 3));
			wstb();
			frame_sync_input <= 1'b1;
			@(posedge mclk_i);
			frame_sync_input <= 1'b0;
			lat = ~lat;
			repeat (6) @(posedge mclk_i);
			apb(A_ST, 1'b0, 32'h0);
			chk(rd[5:4], {1'b1, lat}, "sync latched and held");
			wstb();
			chk(samp.word[sel - 1][0], lat, "sync bit placed");
			apb(A_ST, 1'b0, 32'h0);
			chk(rd[5], 1'b0, "sync hold released");
		end
		apb(A_SU, 1'b1, 32'h0000_0003);
		wstb();
		step <= 1'b1;
		@(posedge mclk_i);
		step <= 1'b0;
		wstb();
		wstb();
		chk(samp.word[2] !== 16'(GY + 16'h0910), 1'b1, "filter smooths step");
		apb(A_GC, 1'b1, 32'h0000_0001);
		wstb();
		wstb();
		chk(samp.word[2], 16'(GY + 16'h0910), "bypass passes raw");
		report_and_stop();
	end
endmodule
`default_nettype wire

// ==== rtl/motion_cfg_pkg.sv ====
// Constants, register map and carriers for the motion sample output block
package motion_cfg_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned PER_32K_NS    = 31250;
	localparam int unsigned PER_8K_NS     = 125000;
	localparam int unsigned PER_1K_NS     = 1000000;
	localparam int unsigned CYC_32K       = PER_32K_NS / CLK_PERIOD_NS;
	localparam int unsigned CYC_8K        = PER_8K_NS / CLK_PERIOD_NS;
	localparam int unsigned CYC_1K        = PER_1K_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_W        = 20;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_Y_BIAS_HIGH = 10'h015;
	localparam logic [9:0] IDX_Y_BIAS_LOW  = 10'h016;
	localparam logic [9:0] IDX_Z_BIAS_HIGH = 10'h017;
	localparam logic [9:0] IDX_Z_BIAS_LOW  = 10'h018;
	localparam logic [9:0] IDX_RATE_DIV    = 10'h019;
	localparam logic [9:0] IDX_SETUP       = 10'h01A;
	localparam logic [9:0] IDX_GYRO_CFG    = 10'h01B;
	localparam logic [9:0] IDX_STATUS      = 10'h020;

	localparam logic [7:0] REG_RESET       = 8'h00;
	localparam int unsigned CFG_UNUSED_BIT = 7;
	localparam int unsigned CFG_FIFO_MODE  = 6;
	localparam int unsigned CFG_SYNC_MSB   = 5;
	localparam int unsigned CFG_SYNC_LSB   = 3;
	localparam int unsigned CFG_LPF_MSB    = 2;
	localparam int unsigned GCFG_BYP_MSB   = 1;
	localparam int unsigned ST_SYNC_LAT    = 4;
	localparam int unsigned ST_SYNC_HELD   = 5;
	localparam int unsigned ST_DROP_LSB    = 8;

	localparam int unsigned NUM_WORDS  = 7;
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned FIFO_DEPTH = 4;

	typedef struct packed {
		logic [NUM_WORDS-1:0][WORD_W-1:0] word;
	} sample_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage

// ==== rtl/motion_sample_output_config.sv ====
// Offset, rate divider, frame-sync capture and buffered output of motion samples
`timescale 1ns/1ps
`default_nettype none
module motion_sample_output_config #(
	parameter int unsigned PER_8K_CYC = motion_cfg_pkg::CYC_8K,
	parameter int unsigned PER_1K_CYC = motion_cfg_pkg::CYC_1K,
	parameter int unsigned FIFO_DEPTH = motion_cfg_pkg::FIFO_DEPTH
) (
	input  wire logic                     mclk_i,             // 100 MHz clock
	input  wire logic                     rst_i,              // Sync reset, high
	input  wire motion_cfg_pkg::apb_req_t apb_i,              // APB request
	output logic [31:0]                   prdata_o,           // APB read data
	output logic                          pready_o,           // APB ready
	output logic                          pslverr_o,          // APB error
	input  wire motion_cfg_pkg::sample_t  raw_i,              // Raw sensor words
	input  wire logic                     frame_sync_input_i, // Async sync pin
	output motion_cfg_pkg::sample_t       samp_o,             // Output registers
	output logic                          samp_stb_o,         // Output updated
	output logic                          fifo_valid_o,       // Buffer not empty
	input  wire logic                     fifo_ready_i,       // Buffer pop
	output motion_cfg_pkg::sample_t       fifo_data_o         // Buffer head
);
	localparam int unsigned LW = $clog2(FIFO_DEPTH+1);
	localparam int unsigned TW = motion_cfg_pkg::TICK_W;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]             y_hi;
		logic [7:0]             y_lo;
		logic [7:0]             z_hi;
		logic [7:0]             z_lo;
		logic [7:0]             div;
		logic [7:0]             cfg;
		logic [7:0]             gcfg;
		logic [TW-1:0]          tick_cnt;
		logic [7:0]             div_cnt;
		logic [2:0]             sync_pipe;
		logic                   sync_lat;
		logic                   sync_held;
		logic                   samp_stb;
		motion_cfg_pkg::sample_t outv;
		logic [2:0][15:0]       filt;
		logic                   pready;
		logic                   pslverr;
		logic [31:0]            prdata;
		logic [7:0]             drop_cnt;
	} state_t;

	state_t             s_q;
	state_t             s_d;
	logic [1:0]         bypass;
	logic [2:0]         lpf;
	logic [2:0]         sync_sel;
	logic               div_on;
	logic [TW-1:0]      per_sel;
	logic               tick;
	logic               samp_now;
	logic               toggle;
	logic               setup;
	logic               access;
	logic [9:0]         idx;
	logic               mapped;
	logic [31:0]        rd_word;
	logic [2:0][15:0]   bias;
	logic [2:0][15:0]   filt_next;
	logic signed [16:0] diff [0:2];
	logic signed [16:0] step [0:2];
	logic [15:0]        z_sum;
	motion_cfg_pkg::sample_t next_out;
	motion_cfg_pkg::sample_t fifo_head;
	logic               f_in_ready;
	logic [LW-1:0]      f_level;

	assign bypass   = s_q.gcfg[motion_cfg_pkg::GCFG_BYP_MSB:0];
	assign lpf      = s_q.cfg[motion_cfg_pkg::CFG_LPF_MSB:0];
	assign sync_sel = s_q.cfg[motion_cfg_pkg::CFG_SYNC_MSB:motion_cfg_pkg::CFG_SYNC_LSB];

	// ------------------------------------------------------------
	// Internal rate and sample strobe
	// ------------------------------------------------------------
	assign div_on = (bypass == 2'h0) && (lpf != 3'h0) && (lpf != 3'h7);

	always_comb
	begin
		if (bypass != 2'h0)
			per_sel = TW'(motion_cfg_pkg::CYC_32K);
		else if (lpf == 3'h0 || lpf == 3'h7)
			per_sel = TW'(PER_8K_CYC);
		else
			per_sel = TW'(PER_1K_CYC);
	end

	// Compare with >= so a shorter period after reconfiguring never stalls
	assign tick     = s_q.tick_cnt >= TW'(per_sel - 1'b1);
	assign samp_now = tick && (!div_on || s_q.div_cnt == s_q.div);

	// ------------------------------------------------------------
	// Filter, bias and output word assembly
	// ------------------------------------------------------------
	assign bias[0] = 16'h0000;
	assign bias[1] = {s_q.y_hi, s_q.y_lo};
	assign bias[2] = {s_q.z_hi, s_q.z_lo};
	assign z_sum   = 16'(s_q.filt[2] + bias[2]);

	always_comb
	begin
		for (int a = 0; a < 3; a++)
		begin
			diff[a] = $signed({raw_i.word[a+1][15], raw_i.word[a+1]})
				- $signed({s_q.filt[a][15], s_q.filt[a]});
			step[a] = diff[a] >>> lpf;
			// Settings 0 and 7 are wide band, so they pass straight through
			if (div_on)
				filt_next[a] = 16'(s_q.filt[a] + step[a][15:0]);
			else
				filt_next[a] = raw_i.word[a+1];
		end
	end

	always_comb
	begin
		next_out = raw_i;
		for (int w = 1; w < 4; w++)
			next_out.word[w] = 16'(s_q.filt[w-1] + bias[w-1]);
		if (sync_sel != 3'h0)
			next_out.word[3'(sync_sel - 3'h1)][0] = s_q.sync_lat;
	end

	// ------------------------------------------------------------
	// Frame sync synchroniser and toggle latch
	// ------------------------------------------------------------
	assign toggle = s_q.sync_pipe[1] ^ s_q.sync_pipe[2];

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	assign setup  = apb_i.psel && !apb_i.penable;
	assign access = apb_i.psel && apb_i.penable && s_q.pready;
	assign idx    = apb_i.paddr[11:2];

	always_comb
	begin
		mapped  = apb_i.paddr[1:0] == 2'h0;
		rd_word = 32'h0000_0000;
		case (idx)
			motion_cfg_pkg::IDX_Y_BIAS_HIGH: rd_word[7:0] = s_q.y_hi;
			motion_cfg_pkg::IDX_Y_BIAS_LOW:  rd_word[7:0] = s_q.y_lo;
			motion_cfg_pkg::IDX_Z_BIAS_HIGH: rd_word[7:0] = s_q.z_hi;
			motion_cfg_pkg::IDX_Z_BIAS_LOW:  rd_word[7:0] = s_q.z_lo;
			motion_cfg_pkg::IDX_RATE_DIV:    rd_word[7:0] = s_q.div;
			motion_cfg_pkg::IDX_SETUP:       rd_word[7:0] = s_q.cfg;
			motion_cfg_pkg::IDX_GYRO_CFG:    rd_word[7:0] = s_q.gcfg;
			motion_cfg_pkg::IDX_STATUS:
			begin
				rd_word[LW-1:0]                       = f_level;
				rd_word[motion_cfg_pkg::ST_SYNC_LAT]  = s_q.sync_lat;
				rd_word[motion_cfg_pkg::ST_SYNC_HELD] = s_q.sync_held;
				rd_word[motion_cfg_pkg::ST_DROP_LSB +: 8] = s_q.drop_cnt;
			end
			default: mapped = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_d          = s_q;
		s_d.pready   = setup;
		s_d.samp_stb = samp_now;
		if (setup)
		begin
			s_d.prdata  = apb_i.pwrite ? 32'h0000_0000 : rd_word;
			s_d.pslverr = !mapped;
		end
		if (access && apb_i.pwrite && mapped)
		begin
			case (idx)
				motion_cfg_pkg::IDX_Y_BIAS_HIGH: s_d.y_hi = apb_i.pwdata[7:0];
				motion_cfg_pkg::IDX_Y_BIAS_LOW:  s_d.y_lo = apb_i.pwdata[7:0];
				motion_cfg_pkg::IDX_Z_BIAS_HIGH: s_d.z_hi = apb_i.pwdata[7:0];
				motion_cfg_pkg::IDX_Z_BIAS_LOW:  s_d.z_lo = apb_i.pwdata[7:0];
				motion_cfg_pkg::IDX_RATE_DIV:    s_d.div  = apb_i.pwdata[7:0];
				motion_cfg_pkg::IDX_SETUP:
				begin
					// Unused top bit is held at zero whatever the host writes
					s_d.cfg = {1'b0, apb_i.pwdata[6:0]};
				end
				motion_cfg_pkg::IDX_GYRO_CFG:    s_d.gcfg = apb_i.pwdata[7:0];
				default: s_d.pslverr = s_q.pslverr;
			endcase
		end

		s_d.tick_cnt = tick ? '0 : TW'(s_q.tick_cnt + 1'b1);
		if (tick)
		begin
			s_d.filt = filt_next;
			if (!div_on)
				s_d.div_cnt = 8'h00;
			else if (s_q.div_cnt >= s_q.div)
				s_d.div_cnt = 8'h00;
			else
				s_d.div_cnt = 8'(s_q.div_cnt + 1'b1);
		end

		if (samp_now)
			s_d.outv = next_out;

		s_d.sync_pipe = {s_q.sync_pipe[1:0], frame_sync_input_i};
		if (samp_now)
			s_d.sync_held = 1'b0;
		// A toggle in the capture cycle wins and starts a new hold
		if (toggle && (!s_q.sync_held || samp_now))
		begin
			s_d.sync_lat  = !s_q.sync_lat;
			s_d.sync_held = 1'b1;
		end

		if (samp_now && !f_in_ready && s_q.drop_cnt != 8'hFF)
			s_d.drop_cnt = 8'(s_q.drop_cnt + 1'b1);
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------
	// Output buffer
	// ------------------------------------------------------------
	sample_fifo #(
		.WIDTH ($bits(motion_cfg_pkg::sample_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (mclk_i),
		.rst_i       (rst_i),
		.overwrite_i (!s_q.cfg[motion_cfg_pkg::CFG_FIFO_MODE]),
		.in_valid_i  (samp_now),
		.in_ready_o  (f_in_ready),
		.in_data_i   (next_out),
		.out_valid_o (fifo_valid_o),
		.out_ready_i (fifo_ready_i),
		.out_data_o  (fifo_head),
		.level_o     (f_level)
	);

	assign fifo_data_o = fifo_head;
	assign prdata_o    = s_q.prdata;
	assign pready_o    = s_q.pready;
	assign pslverr_o   = s_q.pslverr;
	assign samp_o      = s_q.outv;
	assign samp_stb_o  = s_q.samp_stb;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_ylow_write: assert property (@(posedge mclk_i) disable iff (rst_i)
		access && apb_i.pwrite && idx == motion_cfg_pkg::IDX_Y_BIAS_LOW
			&& apb_i.paddr[1:0] == 2'h0
		|=> s_q.y_lo == $past(apb_i.pwdata[7:0]))
		else $error("Y bias low byte not stored");

	a_zbias_sum: assert property (@(posedge mclk_i) disable iff (rst_i)
		samp_now |=> samp_o.word[3][15:1] == $past(z_sum[15:1]))
		else $error("Z output does not carry bias");

	a_ybias_sum: assert property (@(posedge mclk_i) disable iff (rst_i)
		samp_now |=> samp_o.word[2][15:1] == $past(16'(s_q.filt[1] + bias[1])) >> 1)
		else $error("Y output does not carry bias");

	a_div_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		tick && div_on && s_q.div_cnt != s_q.div |=> !samp_stb_o)
		else $error("Strobe before divider count ends");

	a_div_ignored: assert property (@(posedge mclk_i) disable iff (rst_i)
		tick && !div_on |=> samp_stb_o)
		else $error("Divider applied while not effective");

	a_rate_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
		bypass != 2'h0 && $stable(bypass) |-> s_q.tick_cnt < TW'(motion_cfg_pkg::CYC_32K)
			|| $past(per_sel) != per_sel)
		else $error("Bypass rate period exceeded");

	a_drop_full: assert property (@(posedge mclk_i) disable iff (rst_i)
		samp_now && s_q.cfg[motion_cfg_pkg::CFG_FIFO_MODE] && f_level == LW'(FIFO_DEPTH)
			&& !fifo_ready_i
		|=> f_level == LW'(FIFO_DEPTH) && $stable(fifo_head))
		else $error("Full buffer accepted a sample");

	a_overwrite: assert property (@(posedge mclk_i) disable iff (rst_i)
		samp_now && !s_q.cfg[motion_cfg_pkg::CFG_FIFO_MODE] && f_level == LW'(FIFO_DEPTH)
		|=> f_level == LW'(FIFO_DEPTH) && $past(f_in_ready))
		else $error("Oldest entry not replaced");

	a_sync_place: assert property (@(posedge mclk_i) disable iff (rst_i)
		samp_now && sync_sel == 3'h3 |=> samp_o.word[2][0] == $past(s_q.sync_lat))
		else $error("Sync bit not placed in Y low byte");

	a_sync_flip: assert property (@(posedge mclk_i) disable iff (rst_i)
		toggle && !s_q.sync_held |=> s_q.sync_lat != $past(s_q.sync_lat) ##0 s_q.sync_held)
		else $error("Sync toggle not latched");

	a_sync_frozen: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_q.sync_held && !samp_now |=> $stable(s_q.sync_lat))
		else $error("Latched sync flipped before capture");

	a_filter_byp: assert property (@(posedge mclk_i) disable iff (rst_i)
		tick && bypass != 2'h0 |=> s_q.filt[0] == $past(raw_i.word[1]))
		else $error("Filter active while bypassed");

	a_top_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
		!s_q.cfg[motion_cfg_pkg::CFG_UNUSED_BIT])
		else $error("Unused setup bit set");

	a_yhigh_write: assert property (@(posedge mclk_i) disable iff (rst_i)
		access && apb_i.pwrite && idx == motion_cfg_pkg::IDX_Y_BIAS_HIGH
			&& apb_i.paddr[1:0] == 2'h0
		|=> s_q.y_hi == $past(apb_i.pwdata[7:0]))
		else $error("Y bias high byte not stored");

	a_zhigh_write: assert property (@(posedge mclk_i) disable iff (rst_i)
		access && apb_i.pwrite && idx == motion_cfg_pkg::IDX_Z_BIAS_HIGH
			&& apb_i.paddr[1:0] == 2'h0
		|=> s_q.z_hi == $past(apb_i.pwdata[7:0]))
		else $error("Z bias high byte not stored");

	a_zlow_write: assert property (@(posedge mclk_i) disable iff (rst_i)
		access && apb_i.pwrite && idx == motion_cfg_pkg::IDX_Z_BIAS_LOW
			&& apb_i.paddr[1:0] == 2'h0
		|=> s_q.z_lo == $past(apb_i.pwdata[7:0]))
		else $error("Z bias low byte not stored");

	a_setup_write: assert property (@(posedge mclk_i) disable iff (rst_i)
		access && apb_i.pwrite && idx == motion_cfg_pkg::IDX_SETUP
			&& apb_i.paddr[1:0] == 2'h0
		|=> s_q.cfg[6:0] == $past(apb_i.pwdata[6:0]))
		else $error("Setup register not stored");

	a_rate_1k: assert property (@(posedge mclk_i) disable iff (rst_i)
		tick && div_on && $stable(per_sel) |-> s_q.tick_cnt == TW'(PER_1K_CYC - 1))
		else $error("Divider base period wrong");

	a_rate_8k: assert property (@(posedge mclk_i) disable iff (rst_i)
		tick && bypass == 2'h0 && !div_on && $stable(per_sel)
		|-> s_q.tick_cnt == TW'(PER_8K_CYC - 1))
		else $error("Wide band period wrong");

	a_rate_32k: assert property (@(posedge mclk_i) disable iff (rst_i)
		tick && bypass != 2'h0 && $stable(per_sel)
		|-> s_q.tick_cnt == TW'(motion_cfg_pkg::CYC_32K - 1))
		else $error("Bypass period wrong");

	a_drop_count: assert property (@(posedge mclk_i) disable iff (rst_i)
		samp_now && !f_in_ready && s_q.drop_cnt != 8'hFF
		|=> s_q.drop_cnt == 8'($past(s_q.drop_cnt) + 8'h01))
		else $error("Dropped sample not counted");

	a_sync_release: assert property (@(posedge mclk_i) disable iff (rst_i)
		samp_now && !toggle |=> !s_q.sync_held)
		else $error("Sync hold not released by strobe");
endmodule
`default_nettype wire

// ==== rtl/sample_fifo.sv ====
// Small sample FIFO with optional overwrite of the oldest entry
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
	parameter int unsigned WIDTH = 112,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic                     clk_i,       // Clock
	input  wire logic                     rst_i,       // Sync reset
	input  wire logic                     overwrite_i, // Full: replace oldest
	input  wire logic                     in_valid_i,  // Push request
	output logic                          in_ready_o,  // Push accepted
	input  wire logic [WIDTH-1:0]         in_data_i,   // Push data
	output logic                          out_valid_o, // Data available
	input  wire logic                     out_ready_i, // Pop request
	output logic [WIDTH-1:0]              out_data_o,  // Head data
	output logic [$clog2(DEPTH+1)-1:0]    level_o      // Entries held
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [CW-1:0]               cnt;
	} fifo_state_t;

	fifo_state_t f_q;
	fifo_state_t f_d;
	logic        full;
	logic        push;
	logic        pop;

	assign full        = f_q.cnt == CW'(DEPTH);
	assign in_ready_o  = !full || overwrite_i;
	assign out_valid_o = f_q.cnt != '0;
	assign out_data_o  = f_q.mem[f_q.rd];
	assign level_o     = f_q.cnt;
	assign push        = in_valid_i && in_ready_o;
	// Overwrite retires the head so that the newest sample still fits
	assign pop         = (out_valid_o && out_ready_i) || (full && in_valid_i && overwrite_i);

	always_comb
	begin
		f_d = f_q;
		if (push)
		begin
			f_d.mem[f_q.wr] = in_data_i;
			f_d.wr          = (f_q.wr == AW'(DEPTH-1)) ? '0 : AW'(f_q.wr + 1'b1);
		end
		if (pop)
			f_d.rd = (f_q.rd == AW'(DEPTH-1)) ? '0 : AW'(f_q.rd + 1'b1);
		if (push && !pop)
			f_d.cnt = CW'(f_q.cnt + 1'b1);
		else if (pop && !push)
			f_d.cnt = CW'(f_q.cnt - 1'b1);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			f_q <= '0;
		else
			f_q <= f_d;
	end
endmodule
`default_nettype wire
